// ==== rtl/egress_mark_rate.sv ====
// per-queue egress priority marking, rate rounding and frame-based loads
// assumes an ahb-lite master, one queue, synchronous packet and stats inputs
//
// Behaviour
// - tagged packets of a marked class get the configured priority value.
// - untagged packets without tag insertion pass unchanged; marking has no effect on them.
// - split marking uses in value for conforming, out value for nonconforming.
// - existing tag keeps its DE bit; an inserted tag carries DE zero.
// - without marking, tagged packets get priority zero.
// - max rounding picks a hardware rate not above the admin rate.
// - min rounding picks a hardware rate not below the admin rate; the code returns the lower rate when the next step overflows 32 bits.
// - closest rounding picks the hardware rate nearest the admin rate.
// - default is closest rounding, CIR and PIR handled separately.
// - Ethernet overhead is offered packet count times 20 bytes.
// - offered load is depth plus received minus discarded octets.
// - other queues use offered load times overhead percentage.
// - percentage applies only to non-Ethernet queues, limited to 100.00.
// - frame offered load is offered load plus overhead.
// - frame CIR is CIR plus CIR times packet-to-frame factor.
// - within-CIR load is min of frame offered load and frame CIR.
// - zero committed weight of queue or parent forces within-CIR to zero.
// - frame PIR is PIR plus PIR times packet-to-frame factor.
// - within-PIR load is min of frame offered load and frame PIR.
// - committed grant limited to within-CIR; excess to within-PIR minus it.
// - a local overhead override replaces the policy-level value.
// - zero percentage uses packet-based statistics directly.
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`include "egress_mark_params.svh"
module egress_mark_rate (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        pkt_valid,
  input  wire logic        pkt_has_tag,
  input  wire logic        pkt_insert_tag,
  input  wire logic        pkt_conform,
  input  wire logic        pkt_de_in,
  input  wire logic [2:0]  forwarding_class_id,
  output logic             out_valid,
  output logic             out_tagged,
  output logic      [2:0]  out_prio,
  output logic             out_de,
  output logic      [2:0]  out_class,
  input  wire logic        stat_valid,
  input  wire logic [31:0] q_depth,
  input  wire logic [31:0] rx_octets,
  input  wire logic [31:0] discard_octets,
  input  wire logic [31:0] offered_pkts,
  input  wire logic        cir_weight_zero,
  input  wire logic        parent_weight_zero,
  input  wire logic [31:0] committed_grant,
  output logic      [31:0] offered_load,
  output logic      [31:0] frame_load,
  output logic      [31:0] frame_cir,
  output logic      [31:0] frame_pir,
  output logic      [31:0] within_cir,
  output logic      [31:0] within_pir,
  output logic      [31:0] excess_limit
);
  logic [15:0] mark_cfg_q;
  logic [5:0]  rule_cfg_q;
  logic [13:0] ovhd_policy_q;
  logic [13:0] ovhd_local_q;
  logic [31:0] cir_admin_q;
  logic [31:0] pir_admin_q;
  logic [31:0] rate_step_q;
  logic [31:0] cir_oper_q;
  logic [31:0] pir_oper_q;
  logic        ph_valid_q;
  logic        ph_write_q;
  logic [7:0]  ph_addr_q;
  logic [31:0] rdata_d;
  logic [13:0] ovhd_eff;
  logic [31:0] cir_oper_d;
  logic [31:0] pir_oper_d;
  logic [31:0] load_d;
  logic [31:0] ovhd_d;
  logic [31:0] fload_d;
  logic [31:0] fcir_d;
  logic [31:0] fpir_d;

  // round an admin rate to a multiple of the hardware step
  function automatic logic [31:0] round_rate(input logic [31:0] admin,
                                             input logic [31:0] step,
                                             input egress_mark_pkg::round_mode_e mode);
    logic [31:0] s;
    logic [31:0] lo;
    logic [32:0] hi;
    logic [31:0] up;
    s  = (step == 32'h0000_0000) ? 32'h0000_0001 : step;
    lo = admin - (admin % s);
    hi = {1'b0, lo} + ((lo == admin) ? 33'h0_0000_0000 : {1'b0, s});
    up = hi[32] ? lo : hi[31:0];
    case (mode)
      egress_mark_pkg::ROUND_MAX: round_rate = lo;
      egress_mark_pkg::ROUND_MIN: round_rate = up;
      default: round_rate = ((admin - lo) <= (up - admin)) ? lo : up;
    endcase
  endfunction : round_rate

  // value plus value times hundredths percentage, rounded down
  function automatic logic [31:0] add_pct(input logic [31:0] v, input logic [13:0] pct);
    logic [63:0] p;
    p = ({32'h0000_0000, v} * {50'h0, pct}) / `OVHD_SCALE;
    add_pct = v + p[31:0];
  endfunction : add_pct

  // value plus value times overhead over load, rounded down; zero load adds nothing
  function automatic logic [31:0] add_ratio(input logic [31:0] v, input logic [31:0] num,
                                            input logic [31:0] den);
    logic [63:0] p;
    p = 64'h0000_0000_0000_0000;
    if (den != 32'h0000_0000) begin
      p = ({32'h0000_0000, v} * {32'h0000_0000, num}) / {32'h0000_0000, den};
    end
    add_ratio = v + p[31:0];
  endfunction : add_ratio

  function automatic logic [31:0] min32(input logic [31:0] a, input logic [31:0] b);
    min32 = (a < b) ? a : b;
  endfunction : min32

  // bus address phase capture
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q  <= 8'h00;
    end else if (clk_en && hready) begin
      ph_valid_q <= hsel && htrans[1];
      ph_write_q <= hwrite;
      ph_addr_q  <= haddr[7:0];
    end
  end

  // register writes in the data phase
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mark_cfg_q    <= 16'h0000;
      rule_cfg_q    <= 6'(`RULE_RESET);
      ovhd_policy_q <= 14'h0000;
      ovhd_local_q  <= 14'h0000;
      cir_admin_q   <= 32'h0000_0000;
      pir_admin_q   <= 32'h0000_0000;
      rate_step_q   <= `RATE_STEP_RESET;
    end else if (clk_en && ph_valid_q && ph_write_q) begin
      case (ph_addr_q)
        `REG_MARK_CFG:    mark_cfg_q <= hwdata[15:0];
        `REG_RULE_CFG:    rule_cfg_q <= hwdata[5:0];
        `REG_OVHD_POLICY: ovhd_policy_q <= (hwdata > `OVHD_MAX_HUND) ?
                                           14'(`OVHD_MAX_HUND) : hwdata[13:0];
        `REG_OVHD_LOCAL:  ovhd_local_q <= (hwdata > `OVHD_MAX_HUND) ?
                                          14'(`OVHD_MAX_HUND) : hwdata[13:0];
        `REG_CIR_ADMIN:   cir_admin_q <= hwdata;
        `REG_PIR_ADMIN:   pir_admin_q <= hwdata;
        `REG_RATE_STEP:   rate_step_q <= hwdata;
        default: ;
      endcase
    end
  end

  // read data decoded from the address phase, loaded into hrdata at its edge
  always_comb begin
    case (haddr[7:0])
      `REG_MARK_CFG:    rdata_d = {16'h0000, mark_cfg_q};
      `REG_RULE_CFG:    rdata_d = {26'h0, rule_cfg_q};
      `REG_OVHD_POLICY: rdata_d = {18'h0, ovhd_policy_q};
      `REG_OVHD_LOCAL:  rdata_d = {18'h0, ovhd_local_q};
      `REG_CIR_ADMIN:   rdata_d = cir_admin_q;
      `REG_PIR_ADMIN:   rdata_d = pir_admin_q;
      `REG_CIR_OPER:    rdata_d = cir_oper_d;
      `REG_PIR_OPER:    rdata_d = pir_oper_d;
      `REG_RATE_STEP:   rdata_d = rate_step_q;
      `REG_STATUS:      rdata_d = {18'h0, ovhd_eff};
      default:          rdata_d = 32'h0000_0000;
    endcase
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && hready) begin
      hrdata <= (hsel && htrans[1] && !hwrite) ? rdata_d : hrdata;
    end
  end

  // operational rates, each with its own constraint; reset code is closest
  assign cir_oper_d = round_rate(cir_admin_q, rate_step_q,
                        egress_mark_pkg::round_mode_e'(rule_cfg_q[3:2]));
  assign pir_oper_d = round_rate(pir_admin_q, rate_step_q,
                        egress_mark_pkg::round_mode_e'(rule_cfg_q[1:0]));

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cir_oper_q <= 32'h0000_0000;
      pir_oper_q <= 32'h0000_0000;
    end else if (clk_en) begin
      cir_oper_q <= cir_oper_d;
      pir_oper_q <= pir_oper_d;
    end
  end

  // packet marking
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      out_valid  <= 1'b0;
      out_tagged <= 1'b0;
      out_prio   <= 3'h0;
      out_de     <= 1'b0;
      out_class  <= 3'h0;
    end else if (clk_en) begin
      out_valid  <= pkt_valid;
      out_class  <= forwarding_class_id;
      out_tagged <= pkt_has_tag || pkt_insert_tag;
      if (!(pkt_has_tag || pkt_insert_tag)) begin
        out_prio <= 3'h0;
      end else if (!mark_cfg_q[`MARK_EN_BIT]) begin
        out_prio <= 3'h0;
      end else if (mark_cfg_q[`MARK_SPLIT_BIT]) begin
        out_prio <= pkt_conform ? mark_cfg_q[`MARK_IN_LSB +: 3]
                                : mark_cfg_q[`MARK_OUT_LSB +: 3];
      end else begin
        out_prio <= mark_cfg_q[`MARK_ALL_LSB +: 3];
      end
      out_de <= pkt_has_tag ? pkt_de_in : 1'b0;
    end
  end

  // frame-based load computation
  assign ovhd_eff = rule_cfg_q[`RULE_LOCAL_BIT] ? ovhd_local_q : ovhd_policy_q;
  assign load_d   = q_depth + rx_octets - discard_octets;
  always_comb begin
    ovhd_d = 32'h0000_0000;
    if (rule_cfg_q[`RULE_ETH_BIT]) begin
      ovhd_d = 32'(offered_pkts * `ETH_OVHD_BYTES);
    end else begin
      ovhd_d = add_pct(load_d, ovhd_eff) - load_d;
    end
  end
  assign fload_d = load_d + ovhd_d;
  assign fcir_d  = rule_cfg_q[`RULE_ETH_BIT] ? add_ratio(cir_oper_q, ovhd_d, load_d)
                   : add_pct(cir_oper_q, ovhd_eff);
  assign fpir_d  = rule_cfg_q[`RULE_ETH_BIT] ? add_ratio(pir_oper_q, ovhd_d, load_d)
                   : add_pct(pir_oper_q, ovhd_eff);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      offered_load <= 32'h0000_0000;
      frame_load   <= 32'h0000_0000;
      frame_cir    <= 32'h0000_0000;
      frame_pir    <= 32'h0000_0000;
      within_cir   <= 32'h0000_0000;
      within_pir   <= 32'h0000_0000;
    end else if (clk_en && stat_valid) begin
      offered_load <= load_d;
      frame_load   <= fload_d;
      frame_cir    <= fcir_d;
      frame_pir    <= fpir_d;
      within_cir   <= (cir_weight_zero || parent_weight_zero) ? 32'h0000_0000
                      : min32(fload_d, fcir_d);
      within_pir   <= min32(fload_d, fpir_d);
    end
  end

  // excess pass ceiling for the scheduler
  assign excess_limit = (committed_grant > within_cir) ? within_pir - within_cir :
                        (within_pir > committed_grant) ? within_pir - committed_grant
                        : 32'h0000_0000;

  a_prio_zero_unmark: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && pkt_valid && !mark_cfg_q[`MARK_EN_BIT] |=> out_prio == 3'h0)
    else $error("unmarked class priority not zero");
  a_prio_all_mark: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && pkt_has_tag && mark_cfg_q[1:0] == 2'h1 |=> out_prio == $past(mark_cfg_q[6:4]))
    else $error("class priority not applied");
  a_prio_untagged: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && !pkt_has_tag && !pkt_insert_tag |=> !out_tagged && out_prio == 3'h0)
    else $error("untagged packet altered");
  a_de_inserted_zero: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && pkt_valid && !pkt_has_tag |=> !out_de)
    else $error("inserted tag de not zero");
  a_de_pass_thru: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && pkt_has_tag |=> out_de == $past(pkt_de_in))
    else $error("existing de changed");
  a_split_conform: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && pkt_has_tag && mark_cfg_q[1:0] == 2'h3 && pkt_conform
    |=> out_prio == $past(mark_cfg_q[10:8]))
    else $error("conforming priority wrong");
  a_split_nonconf: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && pkt_has_tag && mark_cfg_q[1:0] == 2'h3 && !pkt_conform
    |=> out_prio == $past(mark_cfg_q[14:12]))
    else $error("nonconforming priority wrong");
  a_max_not_above: assert property (@(posedge sys_clk) disable iff (srst)
    rule_cfg_q[1:0] == 2'h1 |-> pir_oper_d <= pir_admin_q)
    else $error("max rounding above admin");
  a_min_not_below: assert property (@(posedge sys_clk) disable iff (srst)
    rule_cfg_q[3:2] == 2'h2 && cir_admin_q < 32'hF000_0000 |-> cir_oper_d >= cir_admin_q)
    else $error("min rounding below admin");
  a_closest_near: assert property (@(posedge sys_clk) disable iff (srst)
    rule_cfg_q[3:2] == 2'h0 && rate_step_q < 32'h0001_0000 && cir_admin_q < 32'hF000_0000
    |-> ((cir_oper_d > cir_admin_q) ? cir_oper_d - cir_admin_q : cir_admin_q - cir_oper_d)
        <= (rate_step_q >> 1))
    else $error("closest rounding not nearest");
  a_eth_overhead: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && stat_valid && rule_cfg_q[`RULE_ETH_BIT]
    |=> frame_load - offered_load == $past(offered_pkts) * `ETH_OVHD_BYTES)
    else $error("ethernet overhead wrong");
  a_offered_load: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && stat_valid |=> offered_load == $past(q_depth + rx_octets - discard_octets))
    else $error("offered load wrong");
  a_pct_clamped: assert property (@(posedge sys_clk) disable iff (srst)
    ovhd_policy_q <= `OVHD_MAX_HUND && ovhd_local_q <= `OVHD_MAX_HUND)
    else $error("overhead percentage above limit");
  a_wcir_min: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && stat_valid && !cir_weight_zero && !parent_weight_zero
    |=> within_cir <= frame_cir && within_cir <= frame_load
        && (within_cir == frame_cir || within_cir == frame_load))
    else $error("within cir not the lesser");
  a_wcir_weight: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && stat_valid && parent_weight_zero |=> within_cir == 32'h0000_0000)
    else $error("within cir not forced zero");
  a_wpir_bound: assert property (@(posedge sys_clk) disable iff (srst)
    within_pir <= frame_pir && within_pir <= frame_load
    && (within_pir == frame_pir || within_pir == frame_load))
    else $error("within pir not the lesser");
  a_excess_cap: assert property (@(posedge sys_clk) disable iff (srst)
    committed_grant <= within_cir && within_cir <= within_pir
    |-> excess_limit == within_pir - committed_grant)
    else $error("excess ceiling wrong");
  a_zero_pct_direct: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && stat_valid && !rule_cfg_q[4] && ovhd_eff == 14'h0000
    |=> frame_load == offered_load)
    else $error("zero overhead changed load");
  a_freeze_hold: assert property (@(posedge sys_clk) disable iff (srst)
    !clk_en |=> $stable(out_valid) && $stable(frame_load) && $stable(cir_oper_q)
        && $stable(hrdata))
    else $error("state moved while clock enable low");
endmodule : egress_mark_rate

// ==== rtl/egress_mark_params.svh ====
// egress marking and frame rate constants: offsets, fields, reset values
// assumes inclusion by bare name from the design and bench files
`ifndef EGRESS_MARK_PARAMS_SVH
`define EGRESS_MARK_PARAMS_SVH
`define REG_MARK_CFG      8'h00
`define REG_RULE_CFG      8'h04
`define REG_OVHD_POLICY   8'h08
`define REG_OVHD_LOCAL    8'h0C
`define REG_CIR_ADMIN     8'h10
`define REG_PIR_ADMIN     8'h14
`define REG_CIR_OPER      8'h18
`define REG_PIR_OPER      8'h1C
`define REG_RATE_STEP     8'h20
`define REG_STATUS        8'h24
`define MARK_EN_BIT       0
`define MARK_SPLIT_BIT    1
`define MARK_ALL_LSB      4
`define MARK_IN_LSB       8
`define MARK_OUT_LSB      12
`define RULE_PIR_LSB      0
`define RULE_CIR_LSB      2
`define RULE_ETH_BIT      4
`define RULE_LOCAL_BIT    5
`define RULE_RESET        32'h0000_0000
`define RATE_STEP_RESET   32'h0000_0001
`define ETH_OVHD_BYTES    32'd20
`define OVHD_MAX_HUND     32'd10000
`define OVHD_SCALE        64'd10000
`endif

// ==== rtl/egress_mark_pkg.sv ====
// egress marking and frame rate types
// assumes the params header is on the include path
package egress_mark_pkg;
  typedef enum logic [1:0] {
    ROUND_CLOSEST,
    ROUND_MAX,
    ROUND_MIN,
    ROUND_CLOSEST_ALT
  } round_mode_e;
  typedef logic [31:0] octets_t;
endpackage : egress_mark_pkg

// ==== dv/egress_sched_model.sv ====
// scheduler and queue stand-in: offers stats, grants the committed pass
// assumes one sys_clk shared with the block, called from the bench
`timescale 1ns/100ps
module egress_sched_model (
  input  wire logic        sys_clk,
  input  wire logic [31:0] within_cir,
  output logic             stat_valid,
  output logic      [31:0] q_depth,
  output logic      [31:0] rx_octets,
  output logic      [31:0] discard_octets,
  output logic      [31:0] offered_pkts,
  output logic      [31:0] committed_grant
);
  logic [31:0] demand = 32'h0000_0000;
  initial begin
    stat_valid = 1'b0;
    {q_depth, rx_octets, discard_octets, offered_pkts} = '0;
  end
  // committed pass never above the within-cir load
  assign committed_grant = (demand < within_cir) ? demand : within_cir;
  task automatic offer(input logic [31:0] d, r, x, n, g);
    @(posedge sys_clk);
    demand <= g;
    stat_valid <= 1'b1;
    {q_depth, rx_octets, discard_octets, offered_pkts} <= {d, r, x, n};
    @(posedge sys_clk);
    stat_valid <= 1'b0;
    // released lines show the inverse, not a stale value
    {q_depth, rx_octets, discard_octets, offered_pkts} <= ~{d, r, x, n};
  endtask : offer
endmodule : egress_sched_model

// ==== dv/egress_queue_marking_and_frame_rates_test.sv ====
// self-checking bench: register access, priority marking, frame loads
// assumes the params header on the include path and the scheduler model
`timescale 1ns/100ps
`include "egress_mark_params.svh"
module egress_queue_marking_and_frame_rates_test;
  logic        sys_clk, srst, clk_en, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, cop, pop;
  logic [1:0]  htrans;
  logic [2:0]  hsize, forwarding_class_id, out_prio, out_class;
  logic        pkt_valid, pkt_has_tag, pkt_insert_tag, pkt_conform, pkt_de_in;
  logic        out_valid, out_tagged, out_de, stat_valid;
  logic        cir_weight_zero, parent_weight_zero;
  logic [31:0] q_depth, rx_octets, discard_octets, offered_pkts, committed_grant;
  logic [31:0] offered_load, frame_load, frame_cir, frame_pir;
  logic [31:0] within_cir, within_pir, excess_limit;
  int          err_count = 0;
  int          tests_run = 0;
  assign hready = hreadyout;
  egress_mark_rate u_egress_mark_rate (.sys_clk, .srst, .clk_en, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pkt_valid,
    .pkt_has_tag, .pkt_insert_tag, .pkt_conform, .pkt_de_in, .forwarding_class_id,
    .out_valid, .out_tagged, .out_prio, .out_de, .out_class, .stat_valid, .q_depth,
    .rx_octets, .discard_octets, .offered_pkts, .cir_weight_zero, .parent_weight_zero,
    .committed_grant, .offered_load, .frame_load, .frame_cir, .frame_pir, .within_cir,
    .within_pir, .excess_limit);
  egress_sched_model u_egress_sched_model (.sys_clk, .within_cir, .stat_valid, .q_depth,
    .rx_octets, .discard_octets, .offered_pkts, .committed_grant);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy(output logic [31:0] q);
    do begin
      @(posedge sys_clk);
    end while (hready !== 1'b1);
    q = hrdata;
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    wait_rdy(q);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy(q);
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    bus(1'b1, a, d, rd);
  endtask : wr
  task automatic rchk(input logic [31:0] a, e);
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(rd, e);
  endtask : rchk
  function automatic logic [31:0] rnd(input int m, input logic [31:0] a);
    logic [31:0] f, c;
    f = a / 32'd100 * 32'd100;
    c = (f == a) ? a : f + 32'd100;
    if (m == 1) return f;
    if (m == 2) return c;
    return ((a - f) > (c - a)) ? c : f;
  endfunction : rnd
  task automatic pkt(input logic t, i, c, e, input logic [2:0] k, p);
    pkt_valid <= 1'b1;
    {pkt_has_tag, pkt_insert_tag, pkt_conform, pkt_de_in, forwarding_class_id} <= {t, i, c, e, k};
    @(posedge sys_clk);
    pkt_valid <= 1'b0;
    @(negedge sys_clk);
    chk({23'h0, out_valid, out_tagged, out_de, out_class, (t | i) ? out_prio : 3'h0},
        {23'h0, 1'b1, t | i, t & e, k, (t | i) ? p : 3'h0});
    @(posedge sys_clk);
  endtask : pkt
  task automatic frame(input logic [31:0] d, r, x, n, p, input logic eth, wz);
    logic [63:0] off, fl, fc, fp, wc, wp;
    off = d + r - x;
    fl = off + (eth ? n * `ETH_OVHD_BYTES : off * p / `OVHD_SCALE);
    fc = cop + cop * (eth ? fl - off : p) / (eth ? off : `OVHD_SCALE);
    fp = pop + pop * (eth ? fl - off : p) / (eth ? off : `OVHD_SCALE);
    wc = wz ? 64'h0 : ((fl < fc) ? fl : fc);
    wp = (fl < fp) ? fl : fp;
    u_egress_sched_model.offer(d, r, x, n, 32'd300);
    @(negedge sys_clk);
    chk(offered_load, off[31:0]);
    chk(frame_load, fl[31:0]);
    chk(frame_cir, fc[31:0]);
    chk(frame_pir, fp[31:0]);
    chk(within_cir, wc[31:0]);
    chk(within_pir, wp[31:0]);
    chk(excess_limit, wp[31:0] - ((wc < 64'd300) ? wc[31:0] : 32'd300));
    @(posedge sys_clk);
  endtask : frame
  initial begin
    #2_000_000;
    err_count++;
    test_done();
  end
  initial begin
    {srst, clk_en, hsel, hwrite, hwdata, haddr, htrans, hsize} = {2'b11, 68'h0, 3'b010};
    {pkt_valid, pkt_has_tag, pkt_insert_tag, pkt_conform, pkt_de_in} = 5'h0;
    {forwarding_class_id, cir_weight_zero, parent_weight_zero} = 5'h0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rchk(`REG_RULE_CFG, `RULE_RESET);
    rchk(`REG_RATE_STEP, `RATE_STEP_RESET);
    rchk(`REG_STATUS, 32'h0000_0000);
    rchk(32'h0000_0028, 32'h0000_0000);
    wr(`REG_RATE_STEP, 32'd100);
    wr(`REG_CIR_ADMIN, 32'd1250);
    wr(`REG_PIR_ADMIN, 32'd1260);
    wr(`REG_CIR_OPER, 32'h0000_1234);
    rchk(`REG_CIR_OPER, 32'd1200);
    rchk(`REG_PIR_OPER, 32'd1300);
    for (int m = 1; m < 4; m++) begin
      wr(`REG_RULE_CFG, {28'h0, m[1:0], m[1:0]});
      rchk(`REG_CIR_OPER, rnd(m, 32'd1250));
      rchk(`REG_PIR_OPER, rnd(m, 32'd1260));
    end
    wr(`REG_RULE_CFG, 32'h0000_0009);
    rchk(`REG_CIR_OPER, 32'd1300);
    rchk(`REG_PIR_OPER, 32'd1200);
    wr(`REG_RULE_CFG, 32'h0000_0000);
    wr(`REG_CIR_ADMIN, 32'd500);
    wr(`REG_PIR_ADMIN, 32'd7500);
    cop = 32'd500;
    pop = 32'd7500;
    wr(`REG_OVHD_POLICY, 32'd1000);
    frame(8000, 3000, 1000, 50, 1000, 1'b0, 1'b0);
    wr(`REG_OVHD_POLICY, 32'd333);
    frame(10001, 0, 0, 7, 333, 1'b0, 1'b0);
    wr(`REG_OVHD_LOCAL, 32'd2500);
    wr(`REG_RULE_CFG, 32'h0000_0020);
    rchk(`REG_STATUS, 32'd2500);
    frame(10000, 0, 0, 9, 2500, 1'b0, 1'b0);
    wr(`REG_OVHD_LOCAL, 32'd12000);
    rchk(`REG_STATUS, `OVHD_MAX_HUND);
    frame(10000, 0, 0, 9, `OVHD_MAX_HUND, 1'b0, 1'b0);
    wr(`REG_RULE_CFG, 32'h0000_0030);
    frame(10000, 0, 0, 50, 0, 1'b1, 1'b0);
    wr(`REG_RULE_CFG, 32'h0000_0000);
    wr(`REG_OVHD_POLICY, 32'd0);
    frame(450, 0, 0, 5, 0, 1'b0, 1'b0);
    cir_weight_zero <= 1'b1;
    frame(10000, 0, 0, 5, 0, 1'b0, 1'b1);
    cir_weight_zero <= 1'b0;
    parent_weight_zero <= 1'b1;
    frame(10000, 0, 0, 5, 0, 1'b0, 1'b1);
    parent_weight_zero <= 1'b0;
    clk_en <= 1'b0;
    u_egress_sched_model.offer(32'd1, 32'd2, 32'd3, 32'd4, 32'd300);
    @(negedge sys_clk);
    chk(frame_load, 32'd10000);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    wr(`REG_MARK_CFG, 32'h0000_0051);
    pkt(1'b1, 1'b0, 1'b1, 1'b1, 3'd3, 3'd5);
    pkt(1'b0, 1'b1, 1'b0, 1'b1, 3'd6, 3'd5);
    pkt(1'b0, 1'b0, 1'b1, 1'b0, 3'd2, 3'd0);
    wr(`REG_MARK_CFG, 32'h0000_6253);
    pkt(1'b1, 1'b0, 1'b1, 1'b0, 3'd1, 3'd2);
    pkt(1'b1, 1'b0, 1'b0, 1'b1, 3'd4, 3'd6);
    wr(`REG_MARK_CFG, 32'h0000_0070);
    pkt(1'b1, 1'b0, 1'b1, 1'b1, 3'd7, 3'd0);
    test_done();
  end
endmodule : egress_queue_marking_and_frame_rates_test
